// [rtl/ahpc_pkg.sv]
// Package for the converter host-port control block.
// Assumes a single 100 MHz clock and an AHB-Lite register bus.
package ahpc_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MK = 8'h10;
	localparam logic [7:0] ADDR_SAMPLE = 8'h14;

	// Control field positions
	localparam int CTRL_STANDALONE = 0;
	localparam int CTRL_PE_EN      = 1;

	// Interrupt event positions
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_IGNORE = 1;
	localparam int IRQ_W      = 2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int STEP_NS       = 80;
	localparam int STEP_CYC      = (STEP_NS * CLK_MHZ) / 1000;
	localparam int ACQ_NS        = 600;
	localparam int ACQ_CYC       = (ACQ_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] STEP_CNT = 8'(STEP_CYC - 1);
	localparam logic [7:0] ACQ_CNT  = 8'(ACQ_CYC - 1);
	localparam logic [3:0] BITS_FULL  = 4'hb;
	localparam logic [3:0] BITS_SHORT = 4'h7;
	localparam logic [3:0] NIB_ZERO   = 4'h0;
	localparam logic [3:0] NIB_ON     = 4'hf;
	localparam logic [11:0] RES_ZERO  = 12'h000;

	typedef enum logic [1:0] {
		AHPC_IDLE = 2'b00,
		AHPC_CONV = 2'b01,
		AHPC_ACQ  = 2'b10
	} ahpc_state_t;

	// Converter pin group from the host
	typedef struct packed {
		logic part_enable;
		logic part_select_n;
		logic read_not_convert;
		logic byte_select_short_cycle;
		logic word_width_select;
	} ahpc_ctl_t;

	// Tri-state data pin group
	typedef struct packed {
		logic [11:0] data;
		logic [11:0] oe;
	} ahpc_dout_t;
endpackage : ahpc_pkg

// [rtl/ahpc_port.sv]
// Host-port control of a 12-bit successive-approximation converter.
// Assumes host pins synchronous to hclk; comparator decision from analog side.
`timescale 1ns/100ps
module ahpc_port (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire ahpc_pkg::ahpc_ctl_t ctl,
	input  wire logic               comparator_keep,
	output ahpc_pkg::ahpc_dout_t    dout,
	output logic                    conversion_active,
	output logic                    irq
);
	typedef struct packed {
		ahpc_pkg::ahpc_state_t st;
		logic [11:0] sar;
		logic [11:0] result;
		logic [3:0]  bit_idx;
		logic [3:0]  last_idx;
		logic [7:0]  tmr;
		logic        rnc_prev;
		logic        standalone;
		logic        pe_en;
		logic [1:0]  irq_st;
		logic [1:0]  irq_mk;
		logic        dph;
		logic        dwr;
		logic [7:0]  daddr;
		logic [31:0] rdata;
		ahpc_pkg::ahpc_dout_t dout;
		logic        busy;
		logic        irq;
	} ahpc_regs_t;

	ahpc_regs_t r_r;
	ahpc_regs_t r_nxt;

	// Part selected when enable high and select low
	function automatic logic sel_ok(input ahpc_pkg::ahpc_ctl_t c);
		sel_ok = c.part_enable && !c.part_select_n;
	endfunction

	logic        sel;
	logic        start_req;
	logic        read_act;
	logic [11:0] onehot;
	logic [3:0]  evt;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		r_nxt = r_r;
		evt   = 4'h0;
		sel   = sel_ok(ctl);
		// Stand-alone starts on falling edge, full control on low level;
		// both need the part selected, so a stray strobe cannot convert
		if (r_r.standalone) begin
			start_req = sel && r_r.rnc_prev && !ctl.read_not_convert;
		end else begin
			start_req = sel && !ctl.read_not_convert;
		end
		read_act = sel && ctl.read_not_convert && (r_r.st != ahpc_pkg::AHPC_CONV);
		r_nxt.rnc_prev = ctl.read_not_convert;
		onehot = 12'h001 << r_r.bit_idx;

		unique case (r_r.st)
			ahpc_pkg::AHPC_IDLE: begin
				if (start_req) begin
					r_nxt.st       = ahpc_pkg::AHPC_CONV;
					r_nxt.sar      = 12'h800;                   // Begin with the MSB trial
					r_nxt.bit_idx  = ahpc_pkg::BITS_FULL;
					r_nxt.last_idx = ctl.byte_select_short_cycle ?
						(ahpc_pkg::BITS_FULL - ahpc_pkg::BITS_SHORT) :
						ahpc_pkg::NIB_ZERO;
					r_nxt.tmr      = ahpc_pkg::STEP_CNT;
				end
			end
			ahpc_pkg::AHPC_CONV: begin
				// Further starts only raise the ignore flag here, so none can abort
				if (start_req) begin
					evt[ahpc_pkg::IRQ_IGNORE] = 1'b1;
				end
				if (r_r.tmr != 8'h00) begin
					r_nxt.tmr = r_r.tmr - 8'h01;
				end else begin
					// One decision per step, walking down from the MSB
					r_nxt.sar = comparator_keep ? r_r.sar : (r_r.sar & ~onehot);
					if (r_r.bit_idx == r_r.last_idx) begin
						r_nxt.st     = ahpc_pkg::AHPC_ACQ;
						r_nxt.result = comparator_keep ? r_r.sar : (r_r.sar & ~onehot);
						r_nxt.tmr    = ahpc_pkg::ACQ_CNT;
					end else begin
						r_nxt.bit_idx = r_r.bit_idx - 4'h1;
						r_nxt.sar     = (comparator_keep ? r_r.sar : (r_r.sar & ~onehot))
							| (onehot >> 1);
						r_nxt.tmr     = ahpc_pkg::STEP_CNT;
					end
				end
			end
			ahpc_pkg::AHPC_ACQ: begin
				// Hold status high while the sampler reacquires; reads allowed
				if (start_req) begin
					evt[ahpc_pkg::IRQ_IGNORE] = 1'b1;
				end
				if (r_r.tmr != 8'h00) begin
					r_nxt.tmr = r_r.tmr - 8'h01;
				end else begin
					r_nxt.st = ahpc_pkg::AHPC_IDLE;
					evt[ahpc_pkg::IRQ_DONE] = 1'b1;
				end
			end
			default: r_nxt.st = ahpc_pkg::AHPC_IDLE;
		endcase
		r_nxt.busy = (r_nxt.st != ahpc_pkg::AHPC_IDLE);

		// Output drivers; everything floats outside a read
		r_nxt.dout.data = ahpc_pkg::RES_ZERO;
		r_nxt.dout.oe   = ahpc_pkg::RES_ZERO;
		if (read_act && r_r.pe_en) begin
			if (ctl.word_width_select) begin
				r_nxt.dout.data = r_r.result;
				r_nxt.dout.oe   = {ahpc_pkg::NIB_ON, ahpc_pkg::NIB_ON, ahpc_pkg::NIB_ON};
			end else if (!ctl.byte_select_short_cycle) begin
				r_nxt.dout.data = {r_r.result[11:4], ahpc_pkg::NIB_ZERO};
				r_nxt.dout.oe   = {ahpc_pkg::NIB_ON, ahpc_pkg::NIB_ON,
					ahpc_pkg::NIB_ZERO};
			end else begin
				r_nxt.dout.data = {ahpc_pkg::NIB_ZERO, ahpc_pkg::NIB_ZERO,
					r_r.result[3:0]};
				r_nxt.dout.oe   = {ahpc_pkg::NIB_ZERO, ahpc_pkg::NIB_ON,
					ahpc_pkg::NIB_ON};
			end
		end

		// ------------------------------------------------------------
		// AHB-Lite slave: zero wait states, always OKAY
		// ------------------------------------------------------------
		r_nxt.dph = hsel && hready && htrans[1];
		if (hsel && hready && htrans[1]) begin
			r_nxt.dwr   = hwrite;
			r_nxt.daddr = haddr[7:0];
		end
		// Set wins over write-one-to-clear
		r_nxt.irq_st = r_r.irq_st;
		if (r_r.dph && r_r.dwr) begin
			unique case (r_r.daddr)
				ahpc_pkg::ADDR_CTRL: begin
					r_nxt.standalone = hwdata[ahpc_pkg::CTRL_STANDALONE];
					r_nxt.pe_en      = hwdata[ahpc_pkg::CTRL_PE_EN];
				end
				ahpc_pkg::ADDR_IRQ_ST: r_nxt.irq_st = r_r.irq_st & ~hwdata[1:0];
				ahpc_pkg::ADDR_IRQ_MK: r_nxt.irq_mk = hwdata[1:0];
				default: ;
			endcase
		end
		r_nxt.irq_st = r_nxt.irq_st | evt[1:0];
		r_nxt.irq    = |(r_nxt.irq_st & r_nxt.irq_mk);
		r_nxt.rdata  = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				ahpc_pkg::ADDR_CTRL:   r_nxt.rdata = {30'h0, r_r.pe_en, r_r.standalone};
				ahpc_pkg::ADDR_STATUS: r_nxt.rdata = {28'h0, r_r.bit_idx};
				ahpc_pkg::ADDR_RESULT: r_nxt.rdata = {19'h0, r_r.busy, r_r.result};
				ahpc_pkg::ADDR_IRQ_ST: r_nxt.rdata = {30'h0, r_r.irq_st};
				ahpc_pkg::ADDR_IRQ_MK: r_nxt.rdata = {30'h0, r_r.irq_mk};
				ahpc_pkg::ADDR_SAMPLE: r_nxt.rdata = {20'h0, r_r.sar};
				default:               r_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_r          <= '0;
			r_r.rnc_prev <= 1'b1;
			r_r.pe_en    <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Outputs straight from flip-flops; hreadyout and hresp tied off
	assign hrdata            = r_r.rdata;
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign dout              = r_r.dout;
	assign conversion_active = r_r.busy;
	assign irq               = r_r.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Status brackets the whole conversion, acquisition included
	a_busy_tracks_state: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st != ahpc_pkg::AHPC_IDLE) |-> conversion_active)
		else $error("status low during conversion");
	a_busy_rise: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_IDLE && start_req) |=> conversion_active)
		else $error("status not raised at start");
	a_busy_fall: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_ACQ && r_r.tmr == 8'h00) |=> !conversion_active)
		else $error("status not dropped after acquisition");

	// A started conversion runs to its end; late starts only raise a flag
	a_no_abort: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_CONV) |=> (r_r.st != ahpc_pkg::AHPC_IDLE))
		else $error("conversion aborted");
	a_ignore_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_CONV && start_req)
		|=> r_r.irq_st[ahpc_pkg::IRQ_IGNORE])
		else $error("ignored start not flagged");
	// Pins stay off while the trial register is still moving
	a_no_data_conv: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(r_r.st) == ahpc_pkg::AHPC_CONV |-> dout.oe == 12'h000)
		else $error("data driven during conversion");

	// Starts need the part selected; a read level never converts
	a_start_gated: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_IDLE && !sel_ok(ctl))
		|=> r_r.st == ahpc_pkg::AHPC_IDLE)
		else $error("conversion started while part not selected");
	a_read_decode: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_IDLE && !r_r.standalone && ctl.read_not_convert)
		|=> r_r.st == ahpc_pkg::AHPC_IDLE)
		else $error("read level started a conversion");

	// Pins float unless the part was selected on the edge before
	a_float_unsel: assert property (@(posedge hclk) disable iff (!hresetn)
		!$past(sel_ok(ctl)) |-> dout.oe == 12'h000)
		else $error("data driven while deselected");

	// Pin formats follow width and byte select of the edge before;
	// the pins are registered, so data are held against the past result
	a_word_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(read_act && r_r.pe_en && ctl.word_width_select)
		|-> dout.oe == 12'hfff && dout.data == $past(r_r.result))
		else $error("word read not on all pins");
	a_hi_byte_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(read_act && r_r.pe_en && !ctl.word_width_select && !ctl.byte_select_short_cycle)
		|-> dout.oe == 12'hff0 && dout.data[11:4] == $past(r_r.result[11:4]))
		else $error("high byte read wrong");
	a_byte_hi_nib: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(!ctl.word_width_select && ctl.byte_select_short_cycle))
		|-> dout.oe[11:8] == 4'h0 && dout.data[7:4] == 4'h0)
		else $error("upper nibble driven in low byte read");
	a_lo_byte_data: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(read_act && r_r.pe_en && !ctl.word_width_select && ctl.byte_select_short_cycle)
		|-> dout.oe[7:0] == 8'hff && dout.data[3:0] == $past(r_r.result[3:0]))
		else $error("low byte read wrong");
	a_byte_lo_nib: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(!ctl.word_width_select && !ctl.byte_select_short_cycle))
		|-> dout.oe[3:0] == 4'h0)
		else $error("lower nibble driven in high byte read");

	// Trials walk down one bit per step and stop at the right index;
	// the short cycle leaves the four low trial bits at zero
	a_msb_first: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_CONV && $past(r_r.st) == ahpc_pkg::AHPC_CONV
		&& $changed(r_r.bit_idx)) |-> r_r.bit_idx == $past(r_r.bit_idx) - 4'h1)
		else $error("bit order broken");
	a_short_len: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_IDLE && start_req && ctl.byte_select_short_cycle)
		|=> r_r.last_idx == 4'h4)
		else $error("short cycle length wrong");
	a_full_len: assert property (@(posedge hclk) disable iff (!hresetn)
		(r_r.st == ahpc_pkg::AHPC_IDLE && start_req && !ctl.byte_select_short_cycle)
		|=> r_r.last_idx == 4'h0)
		else $error("full cycle length wrong");

	// Interrupt line is the registered OR of the unmasked flags
	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		irq == |(r_r.irq_st & r_r.irq_mk))
		else $error("interrupt level mismatch");
endmodule // ahpc_port

// [verification/ahpc_cmp_model.sv]
// Comparator model standing on the analog side of the host port.
// Assumes each trial step lasts eight clocks from the rise of
// conversion_active.
`timescale 1ns/100ps
module ahpc_cmp_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        conversion_active,
	input  wire logic [11:0] target,
	output logic             comparator_keep
);
	logic [7:0] cnt_r;
	logic [3:0] idx;
	// ----------------------------------------------------------------
	// Step tracking
	// ----------------------------------------------------------------
	// Counts clocks of a conversion; saturates so it never wraps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt_r <= 8'h00;
		else if (!conversion_active)
			cnt_r <= 8'h00;
		else if (cnt_r != 8'hff)
			cnt_r <= cnt_r + 8'h01;
	end
	// Bit under trial, top first; shifted half a step to tolerate skew
	always_comb begin
		idx = (cnt_r > 8'h04) ? 4'((cnt_r - 8'h04) >> 3) : 4'h0;
		comparator_keep = (idx < 4'hc) ? target[4'hb - idx] : 1'b0;
	end
endmodule // ahpc_cmp_model

// [verification/adc_host_port_control_tb_top.sv]
// Self-checking bench for the converter host port.
// Assumes a zero-wait AHB-Lite slave and the comparator model.
`timescale 1ns/100ps
module adc_host_port_control_tb_top;
	logic                 hclk, hresetn, hsel, hwrite;
	logic                 hreadyout, hresp, keep, active, irq;
	logic [31:0]          haddr, hwdata, hrdata, rd;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	logic [11:0]          target;
	ahpc_pkg::ahpc_ctl_t  ctl;
	ahpc_pkg::ahpc_dout_t dout;
	int                   n_mismatch, cmp_count;

	// Free-running 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	ahpc_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .ctl(ctl), .comparator_keep(keep), .dout(dout),
		.conversion_active(active), .irq(irq));
	ahpc_cmp_model cmp (.hclk(hclk), .hresetn(hresetn),
		.conversion_active(active), .target(target), .comparator_keep(keep));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// One single transfer; each phase held until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		i = 0;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 100);
		q = hrdata;
		chk(32'(hresp), 32'h0);
		if (i >= 100) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	// Full-control start pulse, then part released
	task automatic start(input logic sel);
		ctl <= '{1'b1, 1'b0, 1'b0, sel, 1'b1};
		@(posedge hclk);
		ctl.part_enable <= 1'b0;
		ctl.read_not_convert <= 1'b1;
	endtask
	// Bounded wait for the end of conversion and acquisition
	task automatic wait_done();
		int i;
		i = 0;
		while (active !== 1'b0 && i < 400) begin
			@(posedge hclk);
			i++;
		end
		if (i >= 400) begin
			n_mismatch++;
			wrap_up();
		end
	endtask
	// Read pins; enables compared whole, data only on enabled bits
	task automatic pin(input logic sel, input logic w, input logic [11:0] d,
		input logic [11:0] oe);
		ctl <= '{1'b1, 1'b0, 1'b1, sel, w};
		tick(2);
		chk(32'(dout.oe), 32'(oe));
		chk(32'(dout.data & oe), 32'(d));
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		ctl = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		target = 12'ha5c;
		n_mismatch = 0;
		cmp_count = 0;
		tick(3);
		hresetn <= 1'b1;
		tick(1);
		chk(32'(dout.oe), 32'h0);
		// Full conversion with a start refused mid-way
		bus(1'b1, ahpc_pkg::ADDR_IRQ_MK, 32'h3, rd);
		start(1'b0);
		tick(20);
		chk(32'(active), 32'h1);
		start(1'b0);
		tick(3);
		wait_done();
		chk(32'(irq), 32'h1);
		bus(1'b0, ahpc_pkg::ADDR_IRQ_ST, 32'h0, rd);
		chk(rd, 32'h3);
		bus(1'b0, ahpc_pkg::ADDR_RESULT, 32'h0, rd);
		chk(rd, 32'h00000a5c);
		bus(1'b1, ahpc_pkg::ADDR_IRQ_ST, 32'h3, rd);
		tick(2);
		chk(32'(irq), 32'h0);
		$display("test full conversion done");
		// Pin formats, then part released and deselected
		pin(1'b0, 1'b1, 12'ha5c, 12'hfff);
		pin(1'b0, 1'b0, 12'ha50, 12'hff0);
		pin(1'b1, 1'b0, 12'h00c, 12'h0ff);
		bus(1'b1, ahpc_pkg::ADDR_CTRL, 32'h0, rd);
		pin(1'b0, 1'b1, 12'h000, 12'h000);
		bus(1'b1, ahpc_pkg::ADDR_CTRL, 32'h2, rd);
		ctl.part_enable <= 1'b0;
		tick(2);
		chk(32'(dout.oe), 32'h0);
		ctl <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		tick(2);
		chk(32'(dout.oe), 32'h0);
		ctl.part_enable <= 1'b0;
		tick(1);
		$display("test output formats done");
		// Short cycle keeps only the top eight bits
		start(1'b1);
		tick(3);
		wait_done();
		bus(1'b0, ahpc_pkg::ADDR_RESULT, 32'h0, rd);
		chk(rd, 32'h00000a50);
		bus(1'b0, ahpc_pkg::ADDR_STATUS, 32'h0, rd);
		chk(rd, 32'h4);
		$display("test short cycle done");
		// Stand-alone start on a falling read_not_convert
		target <= 12'h3c7;
		bus(1'b1, ahpc_pkg::ADDR_CTRL, 32'h3, rd);
		bus(1'b0, ahpc_pkg::ADDR_CTRL, 32'h0, rd);
		chk(rd, 32'h3);
		// A falling strobe while the part is disabled must not convert
		ctl.read_not_convert <= 1'b0;
		tick(3);
		chk(32'(active), 32'h0);
		ctl <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		tick(1);
		ctl.read_not_convert <= 1'b0;
		tick(3);
		chk(32'(active), 32'h1);
		ctl.read_not_convert <= 1'b1;
		wait_done();
		bus(1'b0, ahpc_pkg::ADDR_RESULT, 32'h0, rd);
		chk(rd, 32'h000003c7);
		bus(1'b0, 8'h20, 32'h0, rd);
		chk(rd, 32'h0);
		$display("test stand-alone done");
		wrap_up();
	end
endmodule // adc_host_port_control_tb_top
